// ==== pkg/smc_defs.svh ====
`ifndef SMC_DEFS_SVH
`define SMC_DEFS_SVH

// register indices on the device port
`define SMC_OFF_CTRL0      4'h0
`define SMC_OFF_CTRL1      4'h1
`define SMC_OFF_STATUS     4'h2
`define SMC_OFF_CLKSEL     4'h3
`define SMC_OFF_WINSEL     4'h4
`define SMC_OFF_PERIOD_L   4'h5
`define SMC_OFF_PERIOD_H   4'h6
`define SMC_OFF_PERIOD_U   4'h7
`define SMC_OFF_COUNT_L    4'h8
`define SMC_OFF_COUNT_H    4'h9
`define SMC_OFF_COUNT_U    4'ha
`define SMC_OFF_WIDTH_L    4'hb
`define SMC_OFF_WIDTH_H    4'hc
`define SMC_OFF_WIDTH_U    4'hd
`define SMC_OFF_IRQ        4'he

// measure_control_0 fields
`define SMC_C0_EN          7
`define SMC_C0_HALT        5
`define SMC_C0_WIN_POL     4
`define SMC_C0_SIG_POL     3
`define SMC_C0_CLK_POL     2
`define SMC_C0_PS_HI       1
`define SMC_C0_PS_LO       0
`define SMC_C0_MASK        8'hbf

// measure_control_1 fields
`define SMC_C1_RUN         7
`define SMC_C1_REPEAT      6
`define SMC_C1_MODE_HI     3
`define SMC_C1_MODE_LO     0
`define SMC_C1_MASK        8'hcf

// measure_status fields
`define SMC_ST_PERUPD      7
`define SMC_ST_WIDUPD      6
`define SMC_ST_CNTRST      5
`define SMC_ST_COUNTING    2
`define SMC_ST_WINDOW      1
`define SMC_ST_ACQ         0

// irq register fields
`define SMC_IRQ_FLAG       0
`define SMC_IRQ_EN         1

// field widths and limits
`define SMC_CLK_FIELD_W    3
`define SMC_WIN_FIELD_W    5
`define SMC_WIN_SRCS       24
`define SMC_CLK_SRCS       8
`define SMC_CNT_W          24
`define SMC_OWN_MATCH_CODE 5'h08

// reset values
`define SMC_RST_BYTE       8'h00
`define SMC_RST_CNT        24'h000000

`endif

// ==== pkg/smc_pkg.sv ====
package smc_pkg;

  typedef enum logic [3:0] {
    SMC_TIMER       = 4'b0000,
    SMC_GATED_TIMER = 4'b0001,
    SMC_PERIOD_DUTY = 4'b0010,
    SMC_HIGH_LOW    = 4'b0011,
    SMC_WIN_MEASURE = 4'b0100,
    SMC_GATED_WIN   = 4'b0101,
    SMC_TOF         = 4'b0110,
    SMC_CAPTURE     = 4'b0111,
    SMC_COUNTER     = 4'b1000,
    SMC_GATED_CNT   = 4'b1001,
    SMC_WIN_CNT     = 4'b1010
  } smc_mode_type;

  typedef enum logic [2:0] {
    SMC_CLK_SYS_DIV4 = 3'b000,
    SMC_CLK_SYS      = 3'b001,
    SMC_CLK_HF_OSC   = 3'b010,
    SMC_CLK_LF_OSC   = 3'b011,
    SMC_CLK_MF_OSC   = 3'b100,
    SMC_CLK_MF_DIV16 = 3'b101,
    SMC_CLK_SEC_OSC  = 3'b110,
    SMC_CLK_REF_OUT  = 3'b111
  } smc_clk_sel_type;

endpackage

// ==== pkg/smc_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface smc_if;
  logic [3:0]  addr;
  logic [7:0]  wdata;
  logic        wr;
  logic        rd;
  logic [7:0]  rdata;
  logic [7:0]  clk_src;
  logic [23:0] win_src;
  logic        sig_src;
  logic        match;

  modport dev  (input  addr, wdata, wr, rd, clk_src, win_src, sig_src,
                output rdata, match);
  modport host (output addr, wdata, wr, rd, clk_src, win_src, sig_src,
                input  rdata, match);
endinterface
`default_nettype wire

// ==== src/smc_dev.sv ====
// Operation
// - period match raises an interrupt event
// - match sets flag, gated by enable
// - enable bit 7; off clears prescaler and pending match
// - disabling leaves software registers unchanged
// - halt on: counter holds at period
// - halt off: counter wraps to zero
// - window polarity bit 4 selects active level
// - signal polarity bit 3 selects edge
// - clock polarity bit 2 selects edge
// - prescaler divides by 1, 2, 4, 8
// - run bit starts counting; hardware may clear
// - repeat bit chooses continuous or single
// - four-bit mode field, codes 11+ reserved
// - period update request, hardware clears
// - width update request, hardware clears
// - counter reset request, hardware clears
// - status bit 2 shows counter incrementing
// - status bit 1 shows window open
// - status bit 0 shows acquisition active
// - three-bit clock source select
// - five-bit window source select, 24+ reserved
// - own match code reserved as window
`timescale 1ns/1ps
`default_nettype none
`include "smc_defs.svh"
module smc_dev (
  // clock, reset, enable
  input  wire logic clk_in,
  input  wire logic rst_in,
  input  wire logic ce_in,
  // link to the controller
  smc_if.dev        bus,
  // user side
  output logic      irq_out,
  output logic      match_out
);

  localparam int SRC_W = 1 + `SMC_WIN_SRCS + `SMC_CLK_SRCS;

  // synchroniser group: every source arrives from outside this clock
  logic [SRC_W-1:0] sync1_r, sync1_nxt;
  logic [SRC_W-1:0] sync2_r, sync2_nxt;

  always_comb begin
    sync1_nxt = {bus.sig_src, bus.win_src, bus.clk_src};
    sync2_nxt = sync1_r;
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else if (ce_in) begin
      sync1_r <= sync1_nxt;
      sync2_r <= sync2_nxt;
    end
  end

  // software-visible registers
  logic [7:0]  ctrl0_r, ctrl0_nxt;
  logic [7:0]  ctrl1_r, ctrl1_nxt;
  logic [2:0]  req_r, req_nxt;
  logic [2:0]  clock_source_field_r, clock_source_field_nxt;
  logic [4:0]  window_source_field_r, window_source_field_nxt;
  logic [23:0] period_buf_r, period_buf_nxt;
  logic [23:0] count_r, count_nxt;
  logic [23:0] width_r, width_nxt;
  logic        flag_r, flag_nxt;
  logic        irq_en_r, irq_en_nxt;
  // internal state
  logic [23:0] period_r, period_nxt;
  logic        clk_prev_r, clk_prev_nxt;
  logic        sig_prev_r, sig_prev_nxt;
  logic [2:0]  pre_cnt_r, pre_cnt_nxt;
  logic        match_pend_r, match_pend_nxt;
  logic        match_r, match_nxt;
  logic        counting_r, counting_nxt;
  logic        irq_r, irq_nxt;
  logic [7:0]  rdata_r, rdata_nxt;

  logic [7:0]  src_clk;
  logic [23:0] src_win;
  logic        src_sig;
  logic        en, run, halt;
  logic [3:0]  mode;
  logic        clk_lvl, clk_edge, sig_lvl, sig_edge, win_lvl, win_ok;
  logic        base_edge, gate, tick, advance, at_period;
  logic [2:0]  pre_mask;
  logic [7:0]  status;
  logic [23:0] count_sw;

  assign {src_sig, src_win, src_clk} = sync2_r;
  assign en   = ctrl0_r[`SMC_C0_EN];
  assign run  = ctrl1_r[`SMC_C1_RUN];
  assign halt = ctrl0_r[`SMC_C0_HALT];
  assign mode = ctrl1_r[`SMC_C1_MODE_HI:`SMC_C1_MODE_LO];

  always_comb begin
    clk_lvl  = src_clk[clock_source_field_r] ^ ctrl0_r[`SMC_C0_CLK_POL];
    clk_edge = clk_lvl & ~clk_prev_r;
    sig_lvl  = src_sig ^ ctrl0_r[`SMC_C0_SIG_POL];
    sig_edge = sig_lvl & ~sig_prev_r;
    // reserved codes give a closed window
    win_ok   = (window_source_field_r < 5'(`SMC_WIN_SRCS))
             && (window_source_field_r != `SMC_OWN_MATCH_CODE);
    win_lvl  = win_ok & (src_win[window_source_field_r]
             ^ ctrl0_r[`SMC_C0_WIN_POL]);
    // mode decides time base and gate
    base_edge = mode[3] ? sig_edge : clk_edge;
    unique case (mode)
      smc_pkg::SMC_GATED_TIMER,
      smc_pkg::SMC_GATED_WIN: gate = sig_lvl;
      smc_pkg::SMC_GATED_CNT,
      smc_pkg::SMC_WIN_CNT:   gate = win_lvl;
      smc_pkg::SMC_TIMER,
      smc_pkg::SMC_PERIOD_DUTY,
      smc_pkg::SMC_HIGH_LOW,
      smc_pkg::SMC_WIN_MEASURE,
      smc_pkg::SMC_TOF,
      smc_pkg::SMC_CAPTURE,
      smc_pkg::SMC_COUNTER:   gate = 1'b1;
      default:                gate = 1'b0;
    endcase
    // prescale mask 0, 1, 3, 7
    pre_mask = {ctrl0_r[1:0] == 2'b11, ctrl0_r[1], |ctrl0_r[1:0]};
    tick     = base_edge & (pre_cnt_r == pre_mask);
    // count only while run bit set
    advance   = en & run & gate & tick;
    at_period = (count_r == period_r);
    status = {req_r, 2'b00, counting_r, win_lvl, en & run};
  end

  always_comb begin
    ctrl0_nxt      = ctrl0_r;
    ctrl1_nxt      = ctrl1_r;
    req_nxt        = req_r;
    clock_source_field_nxt  = clock_source_field_r;
    window_source_field_nxt = window_source_field_r;
    period_buf_nxt = period_buf_r;
    count_sw       = count_r;
    width_nxt      = width_r;
    irq_en_nxt     = irq_en_r;
    period_nxt     = period_r;
    rdata_nxt      = rdata_r;
    clk_prev_nxt   = clk_lvl;
    sig_prev_nxt   = sig_lvl;
    pre_cnt_nxt    = pre_cnt_r;
    match_pend_nxt = 1'b0;

    // requests are served before software writes, so a fresh set wins
    // period buffer update
    if (req_r[2]) begin
      period_nxt  = period_buf_r;
      req_nxt[2]  = 1'b0;
    end
    if (req_r[1]) begin
      width_nxt  = count_r;
      req_nxt[1] = 1'b0;
    end
    if (req_r[0]) begin
      count_sw   = `SMC_RST_CNT;
      req_nxt[0] = 1'b0;
    end

    if (base_edge && gate) begin
      pre_cnt_nxt = tick ? 3'h0 : pre_cnt_r + 3'h1;
    end
    if (advance) begin
      if (at_period) begin
        match_pend_nxt = 1'b1;
        count_sw = halt ? count_r : `SMC_RST_CNT;
        if (!ctrl1_r[`SMC_C1_REPEAT]) begin
          ctrl1_nxt[`SMC_C1_RUN] = 1'b0;
        end
      end else begin
        count_sw = count_r + 24'h000001;
      end
    end

    // disabled timer clears its prescaler and pending match only
    // software registers kept as they are
    if (!en) begin
      pre_cnt_nxt    = 3'h0;
      match_pend_nxt = 1'b0;
    end

    if (bus.wr) begin
      unique case (bus.addr)
        `SMC_OFF_CTRL0:    ctrl0_nxt = bus.wdata & `SMC_C0_MASK;
        `SMC_OFF_CTRL1:    ctrl1_nxt = bus.wdata & `SMC_C1_MASK;
        `SMC_OFF_STATUS:   req_nxt = req_nxt | bus.wdata[7:5];
        `SMC_OFF_CLKSEL:   clock_source_field_nxt = bus.wdata[2:0];
        `SMC_OFF_WINSEL:   window_source_field_nxt = bus.wdata[4:0];
        `SMC_OFF_PERIOD_L: period_buf_nxt[7:0] = bus.wdata;
        `SMC_OFF_PERIOD_H: period_buf_nxt[15:8] = bus.wdata;
        `SMC_OFF_PERIOD_U: period_buf_nxt[23:16] = bus.wdata;
        `SMC_OFF_COUNT_L:  count_sw[7:0] = bus.wdata;
        `SMC_OFF_COUNT_H:  count_sw[15:8] = bus.wdata;
        `SMC_OFF_COUNT_U:  count_sw[23:16] = bus.wdata;
        `SMC_OFF_IRQ:      irq_en_nxt = bus.wdata[`SMC_IRQ_EN];
        default: ;
      endcase
    end
    count_nxt = count_sw;

    // flag fed from registered match, never the raw compare
    flag_nxt = flag_r;
    if (bus.wr && bus.addr == `SMC_OFF_IRQ) begin
      flag_nxt = flag_r & bus.wdata[`SMC_IRQ_FLAG];
    end
    if (match_r) begin
      flag_nxt = 1'b1;
    end
    match_nxt    = match_pend_r;
    counting_nxt = en & run & gate;
    irq_nxt      = flag_nxt & irq_en_nxt;

    if (bus.rd) begin
      unique case (bus.addr)
        `SMC_OFF_CTRL0:    rdata_nxt = ctrl0_r;
        `SMC_OFF_CTRL1:    rdata_nxt = ctrl1_r;
        `SMC_OFF_STATUS:   rdata_nxt = status;
        `SMC_OFF_CLKSEL:   rdata_nxt = {5'h00, clock_source_field_r};
        `SMC_OFF_WINSEL:   rdata_nxt = {3'h0, window_source_field_r};
        `SMC_OFF_PERIOD_L: rdata_nxt = period_buf_r[7:0];
        `SMC_OFF_PERIOD_H: rdata_nxt = period_buf_r[15:8];
        `SMC_OFF_PERIOD_U: rdata_nxt = period_buf_r[23:16];
        `SMC_OFF_COUNT_L:  rdata_nxt = count_r[7:0];
        `SMC_OFF_COUNT_H:  rdata_nxt = count_r[15:8];
        `SMC_OFF_COUNT_U:  rdata_nxt = count_r[23:16];
        `SMC_OFF_WIDTH_L:  rdata_nxt = width_r[7:0];
        `SMC_OFF_WIDTH_H:  rdata_nxt = width_r[15:8];
        `SMC_OFF_WIDTH_U:  rdata_nxt = width_r[23:16];
        `SMC_OFF_IRQ:      rdata_nxt = {6'h00, irq_en_r, flag_r};
        default:           rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ctrl0_r      <= `SMC_RST_BYTE;
      ctrl1_r      <= `SMC_RST_BYTE;
      req_r        <= 3'h0;
      clock_source_field_r  <= 3'h0;
      window_source_field_r <= 5'h00;
      period_buf_r <= `SMC_RST_CNT;
      period_r     <= `SMC_RST_CNT;
      count_r      <= `SMC_RST_CNT;
      width_r      <= `SMC_RST_CNT;
      flag_r       <= 1'b0;
      irq_en_r     <= 1'b0;
      clk_prev_r   <= 1'b0;
      sig_prev_r   <= 1'b0;
      pre_cnt_r    <= 3'h0;
      match_pend_r <= 1'b0;
      match_r      <= 1'b0;
      counting_r   <= 1'b0;
      irq_r        <= 1'b0;
      rdata_r      <= `SMC_RST_BYTE;
    end else if (ce_in) begin
      ctrl0_r      <= ctrl0_nxt;
      ctrl1_r      <= ctrl1_nxt;
      req_r        <= req_nxt;
      clock_source_field_r  <= clock_source_field_nxt;
      window_source_field_r <= window_source_field_nxt;
      period_buf_r <= period_buf_nxt;
      period_r     <= period_nxt;
      count_r      <= count_nxt;
      width_r      <= width_nxt;
      flag_r       <= flag_nxt;
      irq_en_r     <= irq_en_nxt;
      clk_prev_r   <= clk_prev_nxt;
      sig_prev_r   <= sig_prev_nxt;
      pre_cnt_r    <= pre_cnt_nxt;
      match_pend_r <= match_pend_nxt;
      match_r      <= match_nxt;
      counting_r   <= counting_nxt;
      irq_r        <= irq_nxt;
      rdata_r      <= rdata_nxt;
    end
  end

  assign bus.rdata = rdata_r;
  assign bus.match = match_r;
  assign irq_out   = irq_r;
  assign match_out = match_r;

endmodule
`default_nettype wire

// ==== src/smc_host.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "smc_defs.svh"
module smc_host (
  // clock, reset, enable
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic        ce_in,
  // software port
  input  wire logic [3:0]  addr_in,
  input  wire logic [7:0]  wdata_in,
  input  wire logic        wr_in,
  input  wire logic        rd_in,
  output logic      [7:0]  rdata_out,
  // candidate sources
  input  wire logic [7:0]  clk_src_in,
  input  wire logic [23:0] win_src_in,
  input  wire logic        sig_src_in,
  // link to the device
  smc_if.host              bus,
  // device event seen by the user
  output logic             match_out
);

  logic [7:0]  clk_src_r, clk_src_nxt;
  logic [23:0] win_src_r, win_src_nxt;
  logic        sig_src_r, sig_src_nxt;
  logic        match_r, match_nxt;

  always_comb begin
    clk_src_nxt = clk_src_in;
    win_src_nxt = win_src_in;
    sig_src_nxt = sig_src_in;
    match_nxt   = bus.match;
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      clk_src_r <= 8'h00;
      win_src_r <= 24'h000000;
      sig_src_r <= 1'b0;
      match_r   <= 1'b0;
    end else if (ce_in) begin
      clk_src_r <= clk_src_nxt;
      win_src_r <= win_src_nxt;
      sig_src_r <= sig_src_nxt;
      match_r   <= match_nxt;
    end
  end

  // strobes pass straight through so the read answer keeps its one cycle;
  // a write wins if a master ever raises both, and ce low drops strobes
  // software orders for run, mode and requests travel this path
  assign bus.addr    = addr_in;
  assign bus.wdata   = wdata_in;
  assign bus.wr      = wr_in & ce_in;
  assign bus.rd      = rd_in & ~wr_in & ce_in;
  assign rdata_out   = bus.rdata;
  assign bus.clk_src = clk_src_r;
  assign bus.win_src = win_src_r;
  assign bus.sig_src = sig_src_r;
  assign match_out   = match_r;

endmodule
`default_nettype wire

// ==== testbench/smc_checker.sv ====
`timescale 1ns/1ps
`default_nettype none
module smc_checker (
  input wire logic       clk_in,
  input wire logic       rst_in,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr,
  input wire logic       rd,
  input wire logic [7:0] rdata,
  input wire logic       match
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  // a write followed at once by a read of the same index
  property rback(a, m);
    wr && addr == a ##1 rd && addr == a |=> rdata == ($past(wdata, 2) & m);
  endproperty

  // one idle cycle lets the hardware serve the request first
  property req_done(b);
    wr && addr == 4'h2 && wdata[b] ##1 !wr ##1 rd && addr == 4'h2
      |=> !rdata[b];
  endproperty

  a_ctrl0_readback:
    assert property (rback(4'h0, 8'hbf)) else $error("control 0 readback");
  a_clk_sel_readback:
    assert property (rback(4'h3, 8'h07)) else $error("clock select readback");
  a_win_sel_readback:
    assert property (rback(4'h4, 8'h1f)) else $error("window readback");
  a_ctrl1_readback:
    assert property (wr && addr == 4'h1 && !wdata[7] ##1 rd && addr == 4'h1
      |=> rdata == ($past(wdata, 2) & 8'hcf)) else $error("control 1 readback");
  a_unmapped_zero:
    assert property (rd && addr == 4'hf |=> rdata == 8'h00)
      else $error("unmapped index not zero");
  a_period_req_clear:
    assert property (req_done(7)) else $error("period request not cleared");
  a_width_req_clear:
    assert property (req_done(6)) else $error("width request not cleared");
  a_count_req_clear:
    assert property (req_done(5)) else $error("count request not cleared");
  a_match_one_cycle:
    assert property (match |=> !match) else $error("match longer than a cycle");
  a_idle_status:
    assert property (wr && addr == 4'h1 && !wdata[7] ##1 !wr
      ##1 rd && addr == 4'h2 |=> !rdata[0] && !rdata[2])
      else $error("status busy after stop");

  c_match: cover property (match);
  c_unmapped: cover property (rd && addr == 4'hf);
  c_cnt_req: cover property (wr && addr == 4'h2 && wdata[5]);
endmodule
`default_nettype wire

// ==== testbench/tb_signal_measure_timer_control.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_signal_measure_timer_control;
  logic        clk_in = 0;
  logic        rst_in = 1;
  logic        ce_in = 1'b1;
  logic [3:0]  addr_in = 0;
  logic [7:0]  wdata_in = 0;
  logic        wr_in = 0;
  logic        rd_in = 0;
  logic [7:0]  rdata_out;
  logic [7:0]  clk_src_in = 0;
  logic [23:0] win_src_in = 0;
  logic        sig_src_in = 0;
  logic        host_match, dev_match, irq_out, g;
  logic        rd_d = 0;
  logic        dev_d = 0;
  logic [7:0]  d;
  int          err_count = 0;
  int          total_checks = 0;
  int          match_cnt = 0;
  logic [7:0]  exp_q[$], msk_q[$];
  logic [3:0]  adr_q[$];
  logic [3:0]  ra[4] = '{4'h0, 4'h1, 4'h3, 4'h4};
  logic [7:0]  rm[4] = '{8'hbf, 8'hcf, 8'h07, 8'h1f};

  smc_if bus_if ();
  smc_host smc_host_i (.clk_in(clk_in), .rst_in(rst_in), .ce_in(ce_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .clk_src_in(clk_src_in),
    .win_src_in(win_src_in), .sig_src_in(sig_src_in), .bus(bus_if),
    .match_out(host_match));
  smc_dev smc_dev_i (.clk_in(clk_in), .rst_in(rst_in), .ce_in(ce_in),
    .bus(bus_if), .irq_out(irq_out), .match_out(dev_match));
  smc_checker smc_checker_i (.clk_in(clk_in), .rst_in(rst_in),
    .addr(bus_if.addr), .wdata(bus_if.wdata), .wr(bus_if.wr),
    .rd(bus_if.rd), .rdata(bus_if.rdata), .match(bus_if.match));

  initial begin
    forever #4 clk_in = ~clk_in;
  end

  task automatic chk(string n, logic [23:0] e, logic [23:0] s);
    total_checks++;
    if (s !== e) begin
      err_count++;
      $display("[ERR] %s expected %0h seen %0h", n, e, s);
    end
  endtask

  task automatic wt(int n);
    repeat (n) begin
      @(posedge clk_in);
      wr_in <= 0;
      rd_in <= 0;
    end
  endtask

  // strobes stay up so that accesses can follow each other with no gap
  task automatic op(logic w, logic [3:0] a, logic [7:0] v, logic [7:0] m);
    @(posedge clk_in);
    wr_in <= w;
    rd_in <= !w;
    addr_in <= a;
    wdata_in <= v;
    if (!w) begin
      exp_q.push_back(v & m);
      msk_q.push_back(m);
      adr_q.push_back(a);
    end
  endtask

  task automatic wreg(logic [3:0] a, logic [7:0] v);
    op(1'b1, a, v, 8'hff);
  endtask

  task automatic rreg(logic [3:0] a, logic [7:0] v, logic [7:0] m = 8'hff);
    op(1'b0, a, v, m);
  endtask

  task automatic zero_cnt;
    wreg(4'h2, 8'h20);
    wt(1);
    rreg(4'h2, 8'h00, 8'h20);
  endtask

  task automatic pulse(logic [7:0] m);
    wt(1);
    clk_src_in <= m;
    wt(6);
    clk_src_in <= 8'h00;
    wt(6);
  endtask

  task automatic chk_irq(logic e);
    #1;
    chk("irq", e, irq_out);
  endtask

  task automatic print_verdict;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // read data appear in the cycle after the strobe and hold until the next read
  always @(posedge clk_in) begin
    if (rd_d) begin
      if (exp_q.size() == 0)
        chk("read queue", 24'h1, 24'h0);
      else
        chk($sformatf("reg %0h", adr_q.pop_front()), exp_q.pop_front(),
          rdata_out & msk_q.pop_front());
    end
    if (dev_d || host_match)
      chk("host match", dev_d, host_match);
    if (dev_match)
      match_cnt++;
    rd_d <= rd_in;
    dev_d <= bus_if.match;
  end

  initial begin
    repeat (90000) @(posedge clk_in);
    err_count++;
    print_verdict();
  end

  initial begin
    void'($urandom(32'h66db));
    repeat (2) @(posedge clk_in);
    rst_in <= 0;
    wt(1);
    foreach (ra[i]) rreg(ra[i], 8'h00);
    rreg(4'h2, 8'h00);
    rreg(4'he, 8'h00);
    rreg(4'hf, 8'h00);
    for (int i = 0; i < 16; i++) begin
      d = 8'($urandom);
      // run stays off: no stray match may clear it
      if (i % 4 == 1) d[7] = 1'b0;
      wreg(ra[i % 4], d);
      rreg(ra[i % 4], d & rm[i % 4]);
    end
    foreach (ra[i]) wreg(ra[i], 8'h00);
    wreg(4'h5, 8'h03);
    wreg(4'h2, 8'h80);
    wt(1);
    rreg(4'h2, 8'h00, 8'h80);
    wreg(4'h2, 8'h40);
    wt(1);
    rreg(4'h2, 8'h00, 8'h40);
    wreg(4'he, 8'h02);
    wreg(4'h3, 8'h01);
    wreg(4'h0, 8'h80);
    wreg(4'h1, 8'hc0);
    zero_cnt();
    wt(6);
    rreg(4'h2, 8'h05, 8'h07);
    match_cnt = 0;
    repeat (6) pulse(8'h02);
    chk("matches", 24'h1, match_cnt);
    chk_irq(1'b1);
    rreg(4'h8, 8'h02);
    // a nonzero count proves the width copy really happened
    wreg(4'h2, 8'h40);
    wt(1);
    rreg(4'hb, 8'h02);
    rreg(4'he, 8'h03);
    wreg(4'he, 8'h01);
    wt(2);
    chk_irq(1'b0);
    rreg(4'he, 8'h01);
    wreg(4'he, 8'h02);
    wreg(4'h0, 8'h00);
    pulse(8'h02);
    rreg(4'h8, 8'h02);
    rreg(4'h1, 8'hc0);
    rreg(4'h2, 8'h00, 8'h05);
    wreg(4'h0, 8'ha0);
    zero_cnt();
    repeat (6) pulse(8'h02);
    rreg(4'h8, 8'h03);
    wreg(4'h0, 8'h80);
    wreg(4'h1, 8'h80);
    zero_cnt();
    repeat (5) pulse(8'h02);
    rreg(4'h1, 8'h00);
    rreg(4'h8, 8'h00);
    wreg(4'h5, 8'hff);
    wreg(4'h2, 8'h80);
    for (int p = 0; p < 4; p++) begin
      wreg(4'h0, 8'h80 | p[7:0]);
      wreg(4'h1, 8'hc0);
      zero_cnt();
      repeat (8) pulse(8'h02);
      rreg(4'h8, 8'h08 >> p);
    end
    for (int c = 0; c < 2; c++) begin
      // a polarity change alone may look like an edge: settle, then zero
      wreg(4'h0, {5'b10000, c[0], 2'b00});
      wt(6);
      zero_cnt();
      wt(1);
      clk_src_in <= 8'h02;
      wt(6);
      rreg(4'h8, {7'd0, !c[0]});
      wt(1);
      clk_src_in <= 8'h00;
      wt(6);
      rreg(4'h8, 8'h01);
    end
    wreg(4'h0, 8'h80);
    for (int s = 0; s < 8; s++) begin
      wreg(4'h3, s[7:0]);
      zero_cnt();
      pulse(~(8'h01 << s));
      pulse(8'h01 << s);
      rreg(4'h8, 8'h01);
    end
    // clock enable low: a whole source pulse must go unseen
    wt(1);
    ce_in <= 1'b0;
    pulse(8'h80);
    ce_in <= 1'b1;
    rreg(4'h8, 8'h01);
    for (int lv = 0; lv < 2; lv++) begin
      sig_src_in <= lv[0];
      win_src_in <= {24{lv[0]}};
      for (int m = 0; m < 16; m++) begin
        wreg(4'h1, 8'hc0 | m[7:0]);
        wt(6);
        g = m < 11 && (lv == 1 || !(m inside {1, 5, 9, 10}));
        rreg(4'h2, {5'b0, g, lv[0], 1'b1}, 8'h07);
      end
    end
    sig_src_in <= 1'b0;
    win_src_in <= 24'h0;
    wreg(4'h0, 8'h98);
    wreg(4'h1, 8'hc1);
    wt(6);
    rreg(4'h2, 8'h07, 8'h07);
    wreg(4'h0, 8'h80);
    for (int w = 0; w < 32; w++) begin
      win_src_in <= (w < 24) ? 24'h1 << w : 24'hffffff;
      wreg(4'h4, w[7:0]);
      wt(6);
      rreg(4'h2, {6'b0, w < 24 && w != 8, 1'b0}, 8'h02);
    end
    // counter mode takes its time base from the signal input
    wreg(4'h1, 8'hc8);
    zero_cnt();
    wt(1);
    sig_src_in <= 1'b1;
    wt(6);
    sig_src_in <= 1'b0;
    wt(6);
    rreg(4'h8, 8'h01);
    wreg(4'h1, 8'h00);
    wt(1);
    rreg(4'h2, 8'h00, 8'h05);
    wt(3);
    print_verdict();
  end
endmodule
`default_nettype wire
